// ===== verilog/lbe_pkg.sv
// Shared constants, modes and helpers for the line tester and error inserter
package lbe_pkg;

  // Pattern selection
  typedef enum logic [2:0] {
    PM_PRBS7  = 3'h0,
    PM_PRBS11 = 3'h1,
    PM_PRBS15 = 3'h2,
    PM_QRSS   = 3'h3,
    PM_REPEAT = 3'h4,
    PM_ALTW   = 3'h5,
    PM_DALY   = 3'h6
  } lbe_mode_e;

  // Receive synchroniser states
  typedef enum logic [0:0] {
    SY_HUNT = 1'b0,
    SY_LOCK = 1'b1
  } lbe_sync_e;

  // Widths
  localparam int unsigned PAT_W   = 32;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned ALT_W   = 8;
  localparam int unsigned LFSR_W  = 20;
  localparam int unsigned RATE_W  = 4;
  localparam int unsigned ICNT_W  = 16;
  localparam int unsigned STAT_W  = 4;

  // Status and info bit positions
  localparam int unsigned ST_SYNC = 0;
  localparam int unsigned ST_BERR = 1;
  localparam int unsigned ST_BOVF = 2;
  localparam int unsigned ST_EOVF = 3;

  // Event mask bit positions
  localparam int unsigned MK_SYNC = 0;
  localparam int unsigned MK_BERR = 1;
  localparam int unsigned MK_OVF  = 2;

  // Synchroniser thresholds
  localparam logic [5:0] SYNC_MATCH_LAST = 6'h1f;
  localparam logic [2:0] LOSS_ERRS       = 3'h6;
  localparam logic [4:0] QRSS_ZERO_RUN   = 5'h0e;

  // Last count of an insertion interval: 1 in 2**field bits
  function automatic logic [ICNT_W-1:0] lbe_rate_last(input logic [RATE_W-1:0] field);
    lbe_rate_last = (16'h0001 << field) - 16'h0001;
  endfunction

  // Pseudorandom modes seed the receive reference from the line
  function automatic logic lbe_is_prbs(input lbe_mode_e mode);
    lbe_is_prbs = (mode == PM_PRBS7) || (mode == PM_PRBS11) ||
                  (mode == PM_PRBS15) || (mode == PM_QRSS);
  endfunction

endpackage

// ===== verilog/lbe_pattern_gen.sv
// Pattern engine shared by the transmit generator and the receive reference
`timescale 1ns/100ps
module lbe_pattern_gen (
  // Clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset,
  // Configuration
  input  wire lbe_pkg::lbe_mode_e          i_mode,
  input  wire logic [lbe_pkg::PAT_W-1:0]   i_pattern,
  input  wire logic [lbe_pkg::ALT_W-1:0]   i_alt_count,
  // Sequencing
  input  wire logic                        i_load,
  input  wire logic                        i_step,
  input  wire logic                        i_seed_en,
  input  wire logic                        i_seed_bit,
  // Current pattern bit
  output logic                             o_bit
);
  import lbe_pkg::*;

  logic [LFSR_W-1:0] lfsr_q;
  logic [PAT_W-1:0]  rot_q;
  logic [3:0]        bidx_q;
  logic [ALT_W-1:0]  rep_q;
  logic              word_q;
  logic [4:0]        zrun_q;
  logic              fb;

  // Feedback taps per polynomial
  always_comb begin
    case (i_mode)
      PM_PRBS7:  fb = lfsr_q[6] ^ lfsr_q[5];
      PM_PRBS11: fb = lfsr_q[10] ^ lfsr_q[8];
      PM_PRBS15: fb = lfsr_q[14] ^ lfsr_q[13];
      default:   fb = lfsr_q[19] ^ lfsr_q[16];
    endcase
  end

  // Output select; the rightmost pattern bit goes first
  always_comb begin
    case (i_mode)
      PM_QRSS:   o_bit = (zrun_q >= QRSS_ZERO_RUN) ? 1'b1 : fb;  // Zero suppression
      PM_REPEAT: o_bit = rot_q[0];  // see [RULE2]
      PM_DALY:   o_bit = rot_q[0];  // see [RULE1]
      PM_ALTW:   o_bit = word_q ? i_pattern[WORD_W + 32'(bidx_q)] : i_pattern[bidx_q];  // see [RULE12]
      default:   o_bit = fb;  // see [RULE1]
    endcase
  end

  // Shift register; loading from the all-ones pattern keeps it off the lock-up state
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_load) begin
      lfsr_q <= i_pattern[LFSR_W-1:0];
    end else if (i_step) begin
      lfsr_q <= {lfsr_q[LFSR_W-2:0], i_seed_en ? i_seed_bit : fb};
    end
  end

  // Zero run length for the suppression rule
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_load) begin
      zrun_q <= 5'h00;
    end else if (i_step) begin
      zrun_q <= o_bit ? 5'h00 : ((zrun_q == QRSS_ZERO_RUN) ? zrun_q : zrun_q + 5'h01);
    end
  end

  // Repeating pattern rotates right
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_load) begin
      rot_q <= i_pattern;
    end else if (i_step) begin
      rot_q <= {rot_q[0], rot_q[PAT_W-1:1]};  // see [RULE2]
    end
  end

  // Alternating words: flip after the programmed word count (count 0 means one word)
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_load) begin
      bidx_q <= 4'h0;
      rep_q  <= '0;
      word_q <= 1'b0;
    end else if (i_step) begin
      bidx_q <= bidx_q + 4'h1;
      if (bidx_q == 4'hf) begin
        if (rep_q == i_alt_count) begin
          rep_q  <= '0;
          word_q <= ~word_q;  // see [RULE3]
        end else begin
          rep_q <= rep_q + 8'h01;
        end
      end
    end
  end

endmodule

// ===== verilog/lbe_tester.sv
// Per-port bit-error-rate tester and T1 payload error inserter
//
// Notes on behaviour
// [RULE1] Generate and check PRBS 2E7, 2E11, 2E15, QRSS and the Daly pattern.
// [RULE2] Repeating user pattern of one to thirty-two bits, sent and checked.
// [RULE3] Two alternating 16-bit words, flipping after 1 to 256 words.
// [RULE4] Sync change, bit error and overflow events, each maskable, cause readable.
// [RULE5] Host configures the interface mux before the tester goes active.
// [RULE6] Latched status flags each sync change, bit error or counter overflow.
// [RULE7] Direction bit points the tester at network or backplane side.
// [RULE8] Per-channel selector bits pick transmit and receive timeslots used.
// [RULE9] In T1, separate enables let the tester use the framing bit.
// [RULE10] Host replicates short patterns to 32 bits; rightmost bit first.
// [RULE11] Host loads all pattern bytes with ones for pseudorandom modes.
// [RULE12] Alternating words: low half first word, high half second word.
// [RULE13] In sync, 32-bit bit counter counts each bit, saturates, flags overflow.
// [RULE14] In sync, 24-bit error counter counts errors, saturates, flags overflow.
// [RULE15] Toggling latch/clear clears both counters.
// [RULE16] Error inserter is T1 transmit only, whole frame or chosen channels.
// [RULE17] Last bit of each rate interval inverted; framing bits never counted.
// [RULE18] Error rate changes take effect only on a frame boundary.
// [RULE19] Rate field zero produces no errors even in continuous mode.
// [RULE20] Continuous bit set inserts errors at the rate without limit.
// [RULE21] Host clears continuous, loads count, raises load bit to start.
// [RULE22] Ten-bit error count up to 1023; remaining count always readable.
// [RULE23] Latched flags set on event, clear when the host reads them.
// [RULE24] A new start during counted insertion replaces the remaining count.
`timescale 1ns/100ps
module lbe_tester #(
  parameter int unsigned BIT_CNT_W = 32,
  parameter int unsigned ERR_CNT_W = 24,
  parameter int unsigned NOE_W     = 10
) (
  // Clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_reset,
  // Tester configuration
  input  wire logic                          i_tester_enable,
  input  wire logic                          i_dir_backplane,
  input  wire logic                          i_tx_fbit_use,
  input  wire logic                          i_rx_fbit_use,
  input  wire lbe_pkg::lbe_mode_e            i_pattern_mode,
  input  wire logic [lbe_pkg::PAT_W-1:0]     i_pattern,
  input  wire logic [lbe_pkg::ALT_W-1:0]     i_alt_word_repeat_count,
  input  wire logic                          i_latch_clear_counters,
  input  wire logic [2:0]                    i_event_mask,
  input  wire logic                          i_status_read,
  // Error inserter configuration
  input  wire logic [lbe_pkg::RATE_W-1:0]    i_error_rate_field,
  input  wire logic                          i_continuous,
  input  wire logic                          i_load_error_count,
  input  wire logic [NOE_W-1:0]              i_error_count_load,
  input  wire logic                          i_err_all_channels,
  // Framer data path timing and slot selection
  input  wire logic                          i_t1_mode,
  input  wire logic                          i_bit_stb,
  input  wire logic                          i_frame_start,
  input  wire logic                          i_fbit,
  input  wire logic                          i_tx_timeslot_select,
  input  wire logic                          i_rx_timeslot_select,
  input  wire logic                          i_err_timeslot_select,
  input  wire logic                          i_tx_data,
  input  wire logic                          i_rx_data,
  // Data path outputs
  output logic                               o_tx_data,
  output logic                               o_rx_data,
  // Status
  output logic                               o_in_sync,
  output logic [BIT_CNT_W-1:0]               o_bit_count,
  output logic [ERR_CNT_W-1:0]               o_error_count,
  output logic [lbe_pkg::STAT_W-1:0]         o_tester_event_info,
  output logic [lbe_pkg::STAT_W-1:0]         o_tester_change_status,
  output logic                               o_event,
  output logic [NOE_W-1:0]                   o_errors_remaining
);
  import lbe_pkg::*;

  // Unsupported widths are refused: counters under 2 bits, remaining count outside 1 to 16
  if (BIT_CNT_W < 2 || ERR_CNT_W < 2 || NOE_W < 1 || NOE_W > 16) begin : g_bad_width
    $error("lbe_tester: unsupported counter width");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  lbe_sync_e             sync_q;
  logic [5:0]            match_q;
  logic [5:0]            win_q;
  logic [2:0]            werr_q;
  logic [BIT_CNT_W-1:0]  bcnt_q;
  logic [ERR_CNT_W-1:0]  ecnt_q;
  logic                  bovf_q;
  logic                  eovf_q;
  logic                  lc_q;
  logic [STAT_W-1:0]     stat_q;
  logic [STAT_W-1:0]     info_q;
  logic                  event_q;
  logic                  tx_q;
  logic                  rx_q;
  logic [RATE_W-1:0]     rate_q;
  logic [ICNT_W-1:0]     icnt_q;
  logic [NOE_W-1:0]      noe_q;
  logic                  load_error_count_q;
  logic                  gen_slot;
  logic                  chk_slot;
  logic                  chk_data;
  logic                  gen_bit;
  logic                  ref_bit;
  logic                  miss;
  logic                  lc_rise;
  logic                  load_rise;
  logic                  ins_slot;
  logic                  ins_hit;
  logic                  frame_edge;
  logic                  bcnt_full;
  logic                  ecnt_full;
  logic [STAT_W-1:0]     ev;

  ////////////////////////////////////////////////////////////////////////////////
  // Slot mapping

  // Framing bit is only usable in T1 and only when its own enable is set
  assign gen_slot = i_bit_stb & i_tester_enable &
                    (i_fbit ? (i_t1_mode & i_tx_fbit_use) : i_tx_timeslot_select);  // see [RULE8] see [RULE9]
  assign chk_slot = i_bit_stb & i_tester_enable &
                    (i_fbit ? (i_t1_mode & i_rx_fbit_use) : i_rx_timeslot_select);  // see [RULE8] see [RULE9]
  // Network side checks the line receive stream, backplane side the transmit stream
  assign chk_data = i_dir_backplane ? i_tx_data : i_rx_data;  // see [RULE7]
  assign miss     = chk_data ^ ref_bit;
  assign lc_rise  = i_latch_clear_counters & ~lc_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pattern engines; idle tester holds both at the loaded start point

  lbe_pattern_gen u_tx_gen (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_mode      (i_pattern_mode),
    .i_pattern   (i_pattern),
    .i_alt_count (i_alt_word_repeat_count),
    .i_load      (~i_tester_enable),
    .i_step      (gen_slot),
    .i_seed_en   (1'b0),
    .i_seed_bit  (1'b0),
    .o_bit       (gen_bit)
  );

  // While hunting, PRBS modes seed from the line; fixed patterns slip one bit on a miss
  lbe_pattern_gen u_rx_ref (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_mode      (i_pattern_mode),
    .i_pattern   (i_pattern),
    .i_alt_count (i_alt_word_repeat_count),
    .i_load      (~i_tester_enable),
    .i_step      (chk_slot & (sync_q == SY_LOCK || lbe_is_prbs(i_pattern_mode) || !miss)),
    .i_seed_en   (sync_q == SY_HUNT),
    .i_seed_bit  (chk_data),
    .o_bit       (ref_bit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Receive synchroniser

  // Lock after 32 clean bits; drop after six errors inside a 64-bit window
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !i_tester_enable) begin
      sync_q  <= SY_HUNT;
      match_q <= 6'h00;
      win_q   <= 6'h00;
      werr_q  <= 3'h0;
    end else if (chk_slot) begin
      case (sync_q)
        SY_HUNT: begin
          match_q <= miss ? 6'h00 : match_q + 6'h01;
          win_q   <= 6'h00;
          werr_q  <= 3'h0;
          if (!miss && match_q == SYNC_MATCH_LAST) begin
            sync_q <= SY_LOCK;
          end
        end
        SY_LOCK: begin
          match_q <= 6'h00;
          win_q   <= win_q + 6'h01;
          if (win_q == 6'h3f) begin
            werr_q <= {2'b00, miss};
          end else if (miss) begin
            werr_q <= werr_q + 3'h1;
          end
          if (miss && werr_q == LOSS_ERRS - 3'h1) begin
            sync_q <= SY_HUNT;
          end
        end
        default: begin
          sync_q <= SY_HUNT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit and error counters

  assign bcnt_full = (bcnt_q == {BIT_CNT_W{1'b1}});
  assign ecnt_full = (ecnt_q == {ERR_CNT_W{1'b1}});

  // Latch/clear edge detector
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      lc_q <= 1'b0;
    end else begin
      lc_q <= i_latch_clear_counters;
    end
  end

  // Bit counter saturates rather than wrapping so a long run never reads small
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || lc_rise) begin
      bcnt_q <= '0;  // see [RULE15]
      bovf_q <= 1'b0;
    end else if (chk_slot && sync_q == SY_LOCK) begin
      if (bcnt_full) begin
        bovf_q <= 1'b1;  // see [RULE13]
      end else begin
        bcnt_q <= bcnt_q + 1'b1;  // see [RULE13]
      end
    end
  end

  // Error counter, same saturation policy
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || lc_rise) begin
      ecnt_q <= '0;  // see [RULE15]
      eovf_q <= 1'b0;
    end else if (chk_slot && sync_q == SY_LOCK && miss) begin
      if (ecnt_full) begin
        eovf_q <= 1'b1;  // see [RULE14]
      end else begin
        ecnt_q <= ecnt_q + 1'b1;  // see [RULE14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Events, latched status and event output

  always_comb begin
    ev          = '0;
    ev[ST_SYNC] = chk_slot && (sync_q == SY_HUNT ? (!miss && match_q == SYNC_MATCH_LAST)
                                                 : (miss && werr_q == LOSS_ERRS - 3'h1));
    ev[ST_BERR] = chk_slot && sync_q == SY_LOCK && miss;
    ev[ST_BOVF] = chk_slot && sync_q == SY_LOCK && bcnt_full && !bovf_q;
    ev[ST_EOVF] = chk_slot && sync_q == SY_LOCK && miss && ecnt_full && !eovf_q;
  end

  // A read clears the flags, but an event in the same cycle still lands
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      stat_q <= '0;
    end else begin
      stat_q <= (i_status_read ? '0 : stat_q) | ev;  // see [RULE6] see [RULE23]
    end
  end

  // Cause register: live sync, one-cycle bit-error pulse and overflow state
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      info_q <= '0;
    end else begin
      info_q[ST_SYNC] <= (sync_q == SY_LOCK);  // see [RULE4]
      info_q[ST_BERR] <= ev[ST_BERR];
      info_q[ST_BOVF] <= bovf_q;
      info_q[ST_EOVF] <= eovf_q;
    end
  end

  // Masked events combine onto one flag
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      event_q <= 1'b0;
    end else begin
      event_q <= (stat_q[ST_SYNC] & ~i_event_mask[MK_SYNC]) |
                 (stat_q[ST_BERR] & ~i_event_mask[MK_BERR]) |
                 ((stat_q[ST_BOVF] | stat_q[ST_EOVF]) & ~i_event_mask[MK_OVF]);  // see [RULE4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Payload error inserter

  assign frame_edge = i_bit_stb & i_frame_start;
  assign load_rise  = i_load_error_count & ~load_error_count_q;
  assign ins_slot   = i_bit_stb & i_t1_mode & ~i_fbit &
                      (i_err_all_channels | i_err_timeslot_select);  // see [RULE16] see [RULE17]
  assign ins_hit    = ins_slot && rate_q != '0 && icnt_q == lbe_rate_last(rate_q) &&
                      (i_continuous || noe_q != '0);  // see [RULE19] see [RULE20]

  // Rate is sampled only at the frame start so a frame never mixes two rates
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rate_q <= '0;
    end else if (frame_edge) begin
      rate_q <= i_error_rate_field;  // see [RULE18]
    end
  end

  // Interval counter restarts when the rate actually changes
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || (frame_edge && i_error_rate_field != rate_q)) begin
      icnt_q <= '0;
    end else if (ins_slot && rate_q != '0) begin
      icnt_q <= (icnt_q == lbe_rate_last(rate_q)) ? '0 : icnt_q + 16'h0001;  // see [RULE17]
    end
  end

  // Remaining count; a new start overrides any decrement in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      noe_q  <= '0;
      load_error_count_q <= 1'b0;
    end else begin
      load_error_count_q <= i_load_error_count;
      if (load_rise) begin
        noe_q <= i_error_count_load;  // see [RULE22] see [RULE24]
      end else if (ins_hit && !i_continuous) begin
        noe_q <= noe_q - 1'b1;  // see [RULE22]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data path outputs

  // Generator replaces the stream facing the chosen side; errors only ever hit transmit
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tx_q <= 1'b1;
      rx_q <= 1'b1;
    end else if (i_bit_stb) begin
      tx_q <= ((gen_slot && !i_dir_backplane) ? gen_bit : i_tx_data) ^ ins_hit;  // see [RULE7] see [RULE16]
      rx_q <= (gen_slot && i_dir_backplane) ? gen_bit : i_rx_data;  // see [RULE7]
    end
  end

  assign o_tx_data              = tx_q;
  assign o_rx_data              = rx_q;
  assign o_in_sync              = (sync_q == SY_LOCK);
  assign o_bit_count            = bcnt_q;
  assign o_error_count          = ecnt_q;
  assign o_tester_event_info    = info_q;
  assign o_tester_change_status = stat_q;
  assign o_event                = event_q;
  assign o_errors_remaining     = noe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  sequence s_start;
    i_load_error_count && !load_error_count_q;
  endsequence

  sequence s_lc_edge;
    i_latch_clear_counters && !lc_q;
  endsequence

  a_clear_counters: assert property (s_lc_edge |=> bcnt_q == '0 && ecnt_q == '0)  // see [RULE15]
    else $error("Counters not cleared by latch/clear");

  a_bit_count_step: assert property (chk_slot && sync_q == SY_LOCK && !bcnt_full && !lc_rise  // see [RULE13]
    |=> bcnt_q == $past(bcnt_q) + 1'b1)
    else $error("Bit counter did not advance");

  // Overflow may only rise on an errored bit checked while locked
  a_err_saturate: assert property (ecnt_full && !lc_rise  // see [RULE14]
    |=> ecnt_full && eovf_q == $past(eovf_q | (miss & chk_slot & (sync_q == SY_LOCK))))
    else $error("Error counter left saturation");

  a_zero_rate_quiet: assert property (rate_q == '0 |-> !ins_hit)  // see [RULE19]
    else $error("Error inserted at rate zero");

  a_fbit_untouched: assert property (ins_hit |-> !i_fbit && i_t1_mode)  // see [RULE17]
    else $error("Error inserted on a framing bit or outside T1");

  a_rate_at_frame: assert property ($changed(rate_q) |-> $past(frame_edge))  // see [RULE18]
    else $error("Rate changed away from frame boundary");

  a_start_loads: assert property (s_start |=> noe_q == $past(i_error_count_load))  // see [RULE24]
    else $error("Start did not load the remaining count");

  a_count_limit: assert property (ins_hit && !i_continuous && !load_rise  // see [RULE22]
    |-> noe_q != '0 ##1 noe_q == $past(noe_q) - 1'b1)
    else $error("Counted insertion miscounted");

  a_flag_sticky: assert property (stat_q[ST_BERR] && !i_status_read |=> stat_q[ST_BERR])  // see [RULE23]
    else $error("Status flag lost without a read");

  // Latched flag and cause pulse both show the error one cycle later
  a_event_flags: assert property (ev[ST_BERR] |=> stat_q[ST_BERR] && info_q[ST_BERR])  // see [RULE6]
    else $error("Bit error not latched");

  a_direction: assert property (i_bit_stb && gen_slot && !i_dir_backplane && !ins_hit  // see [RULE7]
    |=> tx_q == $past(gen_bit))
    else $error("Generator bit not on transmit stream");

endmodule

// ===== sim/lbe_framer_model.sv
// Framer data path model: T1 bit timing, framing bit and receive loopback
`timescale 1ns/100ps
module lbe_framer_model (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  // Transmit stream handed back as the receive stream
  input  wire logic i_tx_line,
  // Line bit timing and receive data
  output logic      o_bit_stb = 1'b0,
  output logic      o_frame_start = 1'b0,
  output logic      o_fbit = 1'b0,
  output logic      o_rx_line = 1'b1
);
  logic [7:0] bit_idx_q = 8'h00;
  //////////////////////////////////////////////////////////////////////
  // One bit every second clock, 193 bits a frame, F-bit first.
  // Receive line is inverted between strobes so stale data never looks valid
  always @(negedge i_clk_sys) begin
    if (i_reset || o_bit_stb) begin
      o_bit_stb <= 1'b0;
      o_rx_line <= ~o_rx_line;
      if (i_reset) bit_idx_q <= 8'h00;
    end else begin
      o_bit_stb     <= 1'b1;
      o_frame_start <= (bit_idx_q == 8'h00);
      o_fbit        <= (bit_idx_q == 8'h00);
      o_rx_line     <= i_tx_line;
      bit_idx_q     <= (bit_idx_q == 8'hc0) ? 8'h00 : bit_idx_q + 8'h01;
    end
  end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the line tester and payload error inserter
`timescale 1ns/100ps
module testbench;
  import lbe_pkg::*;
  logic        clk, rst, en, on, lcc, rd, cont, ld, stb, fs, fb, txd, rxd, otx, sync, ev, chk;
  logic        ld_q = 1'b0, lc_q = 1'b0, bp = 1'b0, orx;
  lbe_mode_e   mode;
  logic [31:0] pat, bc, lf;
  logic [7:0]  altc;
  logic [3:0]  fld, stat, info;
  logic [2:0]  msk;
  logic [9:0]  nld, rem;
  logic [23:0] ec;
  int          n_errors, n_compared;
  int          m_rate = 0, m_cnt = 0, m_rem = 0, m_ins = 0, m_err = 0, m_bits = 0;

  lbe_tester u_dut (
    .i_clk_sys(clk), .i_reset(rst), .i_tester_enable(en), .i_dir_backplane(bp), .i_tx_fbit_use(on),
    .i_rx_fbit_use(on), .i_pattern_mode(mode), .i_pattern(pat), .i_alt_word_repeat_count(altc),
    .i_latch_clear_counters(lcc), .i_event_mask(msk), .i_status_read(rd), .i_error_rate_field(fld),
    .i_continuous(cont), .i_load_error_count(ld), .i_error_count_load(nld), .i_err_all_channels(1'b1),
    .i_t1_mode(1'b1), .i_bit_stb(stb), .i_frame_start(fs), .i_fbit(fb), .i_tx_timeslot_select(on),
    .i_rx_timeslot_select(on), .i_err_timeslot_select(1'b0), .i_tx_data(bp ? orx : txd), .i_rx_data(rxd),
    .o_tx_data(otx), .o_rx_data(orx), .o_in_sync(sync), .o_bit_count(bc), .o_error_count(ec),
    .o_tester_event_info(info), .o_tester_change_status(stat), .o_event(ev), .o_errors_remaining(rem));
  lbe_framer_model u_framer (.i_clk_sys(clk), .i_reset(rst), .i_tx_line(otx), .o_bit_stb(stb),
    .o_frame_start(fs), .o_fbit(fb), .o_rx_line(rxd));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("Compared %0d values, %0d mismatches", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wait_bits(input int n);
    repeat (2 * n) @(negedge clk);
  endtask
  // Frame=1 waits for a frame start, else for sync; a spent bound is a failure
  task automatic wait_on(input logic frame);
    int k;
    for (k = 0; k < 20000; k++) begin
      @(negedge clk);
      if (frame ? (stb === 1'b1 && fs === 1'b1) : (sync === 1'b1)) break;
    end
    if (k == 20000) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic pulse_read();
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic load_count(input logic [9:0] n);
    nld = n;
    ld = 1'b1;
    @(negedge clk);
    ld = 1'b0;
  endtask
  // Clear lands on an edge with no strobe, so no count races the clear
  task automatic clear_counts();
    repeat (2) if (stb !== 1'b1) @(negedge clk);
    lcc = 1'b1;
    @(negedge clk);
    lcc = 0;
  endtask
  // Rate 0 over a whole frame first, so the interval restarts at a known bit
  task automatic arm(input logic [9:0] n, input logic [3:0] r, input logic c);
    fld = 4'h0;
    wait_on(1'b1);
    cont = c;
    load_count(n);
    wait_on(1'b1);
    fld = r;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reference inserter and counters; an error is seen one strobe after it is sent
  always @(posedge clk) begin
    if (lcc && !lc_q) begin
      m_bits = 0;
      m_ins = m_ins - m_err;
      m_err = 0;
    end
    if (stb) begin
      m_err = m_ins;
      m_bits++;
      if (fs && fld != m_rate) begin
        m_rate = fld;
        m_cnt = 0;
      end
      if (!fb && m_rate != 0) m_cnt++;
      if (m_rate != 0 && m_cnt == (1 << m_rate)) begin
        m_cnt = 0;
        if (cont || m_rem > 0) m_ins++;
        if (!cont && m_rem > 0) m_rem--;
      end
    end
    if (ld && !ld_q) m_rem = nld;
    ld_q = ld;
    lc_q = lcc;
  end
  // Compare counters at every cycle once counting has been armed
  always @(negedge clk) begin
    // Network side passes the receive stream through, registered on the same strobe
    if (stb && !bp) check(orx, rxd);
    if (chk) begin
      check(rem, m_rem);
      check(ec, m_err);
      check(bc, m_bits);
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, en, on, lcc, rd, cont, ld, chk, txd} = 9'h140;
    {fld, msk, nld, altc} = 25'h0;
    mode = PM_PRBS7;
    pat = 32'hffffffff;
    lf = 32'he84acac8;
    n_errors = 0;
    n_compared = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check(rem, 32'h0);
    check(bc, 32'h0);
    // Every pattern kind must reach sync over the loopback; odd modes face the backplane
    for (int m = 0; m < 7; m++) begin
      en = 1'b0;
      wait_bits(4);
      check(sync, 1'b0);
      lf = lfsr_next(lf);
      mode = lbe_mode_e'(m);
      bp = m[0];
      {pat, altc, txd} = {(m < 4) ? 32'hffffffff : lf, lf[7:0], lf[9]};
      pulse_read();
      check(stat, 32'h0);
      en = 1'b1;
      wait_on(1'b0);
      check(sync, 1'b1);
      @(negedge clk);
      check(stat[0], 1'b1);
      check(info[0], 1'b1);
      $display("test pattern mode %0d done", m);
    end
    clear_counts();
    chk = 1'b1;
    lf = lfsr_next(lf);
    arm({8'h00, lf[1:0]} + 10'h003, 4'h4, 1'b0);
    wait_on(1'b1);
    wait_bits(40);
    load_count({8'h00, lf[3:2]} + 10'h001);
    wait_bits(400);
    check(stat[1], 1'b1);
    check(ev, 1'b1);
    pulse_read();
    check(stat, 32'h0);
    @(negedge clk);
    check(ev, 1'b0);
    $display("test counted insertion done");
    msk = 3'h7;
    arm(10'h000, 4'h5, 1'b1);
    wait_bits(800);
    check(stat[1], 1'b1);
    check(ev, 1'b0);
    clear_counts();
    wait_bits(100);
    $display("test continuous insertion done");
    chk = 1'b0;
    close_out();
  end
endmodule
